/* hw/awn_pkg.sv */
// constants and carrier types for the asynchronous write sequencer
package awn_pkg;
	localparam int CS_COUNT  = 4;    // chip selects served
	localparam int CS_IDX_W  = 2;
	localparam int ADDR_W    = 23;   // address pin width
	localparam int BANK_W    = 2;    // bank address pin width
	localparam int WORD_W    = 32;   // request word width
	localparam int DATA_W    = 16;   // external data pin width
	localparam int BE_W      = DATA_W / 8;
	localparam int BEATS_W   = 1;    // extra access cycles field
	localparam int TA_W      = 2;
	localparam int SETUP_W   = 4;
	localparam int STROBE_W  = 6;
	localparam int HOLD_W    = 3;
	localparam int CNT_W     = 6;
	localparam int FIFO_DEPTH = 32;

	localparam logic [CS_COUNT-1:0] CS_IDLE   = 4'hF;
	localparam logic [BE_W-1:0]     BE_IDLE   = 2'h3;
	localparam logic [TA_W-1:0]     TA_ZERO   = 2'h0;
	localparam logic [TA_W-1:0]     TA_AFTER_READ = 2'h1;

	// one write request as queued from the requesters
	typedef struct packed {
		logic [CS_IDX_W-1:0] cs;
		logic [ADDR_W-1:0]   addr;
		logic [BANK_W-1:0]   bank;
		logic [WORD_W-1:0]   data;
		logic [WORD_W/8-1:0] be_n;
		logic [BEATS_W-1:0]  extra;
	} awn_req_t;

	// per chip select write timing
	typedef struct packed {
		logic [TA_W-1:0]     ta;
		logic [SETUP_W-1:0]  setup;
		logic [STROBE_W-1:0] strobe;
		logic [HOLD_W-1:0]   hold;
	} awn_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TURN,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} awn_state_t;
endpackage

/* hw/awn_sync3.sv */
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module awn_sync3 #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// level in and filtered level out
	input  wire logic din,
	output logic      dout
);
	logic s1;
	logic s2;
	logic s3;

	// shift chain, first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// output follows only when the later stages agree
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dout <= RESET_VAL;
		end else if (s2 == s3) begin
			dout <= s3;
		end
	end
endmodule

/* hw/awn_fifo.sv */
// request queue built from flip-flops, valid and ready on both sides
`timescale 1ns/1ns
module awn_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wr_ptr;
	logic [PW:0]      rd_ptr;
	logic             push;
	logic             pop;

	// full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
	assign out_valid = (wr_ptr != rd_ptr);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[PW-1:0]];

	// storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr[PW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

/* hw/awn_write_seq.sv */
// asynchronous bank write sequencer, normal mode
// Operation
// - read strobe held high during writes
// - write starts only when top priority
// - repeat access cycles until request done
// - wait programmed turnaround before setup
// - write after write gets no turnaround
// - write after read, zero field: one
// - recheck priority after turnaround, else abandon
// - load setup, strobe, hold at setup
// - address, bank, data valid at setup
// - chip select falls at setup start
// - strobe drives write low, byte enables
// - external wait stretches the strobe phase
// - hold end releases pins, raises select
// - extra beats return to setup directly
`timescale 1ns/1ns
module awn_write_seq #(
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic                                      sys_clk,
	input  wire logic                                      sys_rst,
	// write requests
	input  wire logic                                      req_valid,
	output logic                                           req_ready,
	input  wire awn_pkg::awn_req_t                         req,
	// arbitration
	input  wire logic                                      write_is_top,
	input  wire logic                                      read_done,
	// per chip select timing
	input  wire awn_pkg::awn_cfg_t [awn_pkg::CS_COUNT-1:0] cs_cfg,
	// memory pins
	output logic [awn_pkg::CS_COUNT-1:0]                   chip_select_pins_n,
	output logic [awn_pkg::ADDR_W-1:0]                     address_pins,
	output logic [awn_pkg::BANK_W-1:0]                     bank_address_pins,
	output logic [awn_pkg::DATA_W-1:0]                     data_pins_out,
	output logic                                           data_pins_oe,
	output logic                                           write_strobe_pin_n,
	output logic                                           read_strobe_pin_n,
	output logic [awn_pkg::BE_W-1:0]                       byte_enable_pins_n,
	input  wire logic                                      external_wait_pin,
	// status
	output logic                                           busy,
	output logic                                           write_done
);
	import awn_pkg::*;

	awn_state_t          state;
	logic [CNT_W-1:0]    cnt;
	awn_cfg_t            lat;
	logic [BEATS_W-1:0]  beat;
	logic [BEATS_W:0]    next_beat;
	logic                last_write;
	logic                wait_lvl;
	logic                q_valid;
	logic                q_ready;
	awn_req_t            q_req;
	awn_cfg_t            sel_cfg;
	logic [TA_W-1:0]     turn_len;
	logic                start;
	logic                enter_setup;
	logic                strobe_end;
	logic                hold_end;
	logic                finish;

	// turnaround length for the selected chip select
	function automatic logic [TA_W-1:0] turn_cycles(input logic [TA_W-1:0] ta,
		input logic after_write);
		if (after_write) begin
			turn_cycles = TA_ZERO;
		end else if (ta == TA_ZERO) begin
			turn_cycles = TA_AFTER_READ;
		end else begin
			turn_cycles = ta;
		end
	endfunction

	// request queue in front of the sequencer
	awn_fifo #(
		.WIDTH ($bits(awn_req_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (req),
		.out_valid (q_valid),
		.out_ready (q_ready),
		.out_data  (q_req)
	);

	// wait pin comes from outside the clock domain
	awn_sync3 #(
		.RESET_VAL (1'b0)
	) u_wait_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.din     (external_wait_pin),
		.dout    (wait_lvl)
	);

	// phase decoding
	assign sel_cfg     = cs_cfg[q_req.cs];
	assign turn_len    = turn_cycles(sel_cfg.ta, last_write);
	assign start       = (state == ST_IDLE) && q_valid && write_is_top;
	assign enter_setup = (start && (turn_len == TA_ZERO)) ||
		((state == ST_TURN) && (cnt == '0) && write_is_top);
	assign strobe_end  = (state == ST_STROBE) && (cnt == '0) && !wait_lvl;
	assign hold_end    = (state == ST_HOLD) && (cnt == '0);
	assign finish      = hold_end && (beat == q_req.extra);
	assign q_ready     = finish;
	assign busy        = (state != ST_IDLE);
	assign next_beat   = {1'b0, beat} + 1'b1;

	// phase sequencing
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						state <= (turn_len == TA_ZERO) ? ST_SETUP : ST_TURN;
					end
				end
				ST_TURN: begin
					if (cnt == '0) begin
						state <= write_is_top ? ST_SETUP : ST_IDLE;
					end
				end
				ST_SETUP: begin
					if (cnt == '0) begin
						state <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					if (strobe_end) begin
						state <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (hold_end) begin
						state <= finish ? ST_IDLE : ST_SETUP;
					end
				end
			endcase
		end
	end

	// phase counter, setup, strobe and hold last their field plus one cycle, turnaround lasts its length
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt <= '0;
		end else if (enter_setup) begin
			cnt <= CNT_W'(sel_cfg.setup);
		end else if (start) begin
			cnt <= CNT_W'(turn_len - 1'b1);
		end else if ((state == ST_SETUP) && (cnt == '0)) begin
			cnt <= CNT_W'(lat.strobe);
		end else if (strobe_end) begin
			cnt <= CNT_W'(lat.hold);
		end else if (hold_end && !finish) begin
			cnt <= CNT_W'(lat.setup);
		end else if ((state != ST_IDLE) && (cnt != '0)) begin
			cnt <= cnt - 1'b1;
		end
	end

	// timing latched once per request, kept for extra beats
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lat <= '0;
		end else if (enter_setup) begin
			lat <= sel_cfg;
		end
	end

	// beat counter for narrow devices
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			beat <= '0;
		end else if (enter_setup) begin
			beat <= '0;
		end else if (hold_end && !finish) begin
			beat <= next_beat[BEATS_W-1:0];
		end
	end

	// address, bank and data pins
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			address_pins      <= '0;
			bank_address_pins <= '0;
			data_pins_out     <= '0;
			data_pins_oe      <= 1'b0;
		end else if (enter_setup) begin
			address_pins      <= q_req.addr;
			bank_address_pins <= q_req.bank;
			data_pins_out     <= q_req.data[DATA_W-1:0];
			data_pins_oe      <= 1'b1;
		end else if (hold_end && !finish) begin
			address_pins  <= address_pins + 1'b1;
			data_pins_out <= q_req.data[next_beat*DATA_W +: DATA_W];
		end else if (finish) begin
			data_pins_oe <= 1'b0;
		end
	end

	// chip select, low from setup until the last hold ends
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			chip_select_pins_n <= CS_IDLE;
		end else if (enter_setup) begin
			for (int i = 0; i < CS_COUNT; i++) begin
				chip_select_pins_n[i] <= (q_req.cs != CS_IDX_W'(i));
			end
		end else if (finish) begin
			chip_select_pins_n <= CS_IDLE;
		end
	end

	// write strobe and byte enables during strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			write_strobe_pin_n <= 1'b1;
			byte_enable_pins_n <= BE_IDLE;
		end else if ((state == ST_SETUP) && (cnt == '0)) begin
			write_strobe_pin_n <= 1'b0;
			byte_enable_pins_n <= q_req.be_n[beat*BE_W +: BE_W];
		end else if (strobe_end) begin
			write_strobe_pin_n <= 1'b1;
			byte_enable_pins_n <= BE_IDLE;
		end
	end

	// read strobe stays inactive in this block
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			read_strobe_pin_n <= 1'b1;
		end else begin
			read_strobe_pin_n <= 1'b1;
		end
	end

	// last operation tracking, write completion wins over a read
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			last_write <= 1'b0;
			write_done <= 1'b0;
		end else begin
			write_done <= finish;
			if (finish) begin
				last_write <= 1'b1;
			end else if (read_done) begin
				last_write <= 1'b0;
			end
		end
	end

	// checks
	read_strobe_high_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst) busy |-> read_strobe_pin_n)
		else $error("read strobe active during write");
	start_needs_top_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_IDLE) && !write_is_top |=> (state == ST_IDLE))
		else $error("write started without priority");
	extra_beat_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		hold_end && !finish |=> (state == ST_SETUP) && (chip_select_pins_n != CS_IDLE))
		else $error("extra beat did not return to setup");
	turn_two_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		start && !last_write && (sel_cfg.ta == 2'h2) |=>
		(state == ST_TURN) [*2] ##1 (state != ST_TURN))
		else $error("turnaround length wrong");
	write_write_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst) start && last_write |=> (state == ST_SETUP))
		else $error("turnaround after a write");
	read_ta_zero_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		start && !last_write && (sel_cfg.ta == TA_ZERO) |=> (state == ST_TURN) ##1 (state != ST_TURN))
		else $error("missing single turnaround after read");
	turn_abandon_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_TURN) && (cnt == '0) && !write_is_top |=> (state == ST_IDLE) && !data_pins_oe)
		else $error("write not abandoned");
	setup_pins_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		enter_setup |=> data_pins_oe && (chip_select_pins_n != CS_IDLE) && write_strobe_pin_n)
		else $error("pins not valid at setup start");
	setup_zero_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		enter_setup && (sel_cfg.setup == '0) |=> (state == ST_SETUP) ##1 (state == ST_STROBE))
		else $error("setup length wrong");
	strobe_pins_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_SETUP) && (cnt == '0) |=> !write_strobe_pin_n && (state == ST_STROBE))
		else $error("write strobe not asserted");
	wait_stretch_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(state == ST_STROBE) && wait_lvl |=> (state == ST_STROBE) && !write_strobe_pin_n)
		else $error("strobe ended under wait");
	hold_release_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		finish |=> (chip_select_pins_n == CS_IDLE) && !data_pins_oe && write_done)
		else $error("pins not released after hold");
endmodule

/* tb/awn_mem_model.sv */
// behavioural memory that accepts write beats and can stretch the strobe
`timescale 1ns/1ns
module awn_mem_model (
	// clock
	input  wire logic        sys_clk,
	// pins from the sequencer
	input  wire logic [3:0]  cs_n,
	input  wire logic [22:0] addr,
	input  wire logic [15:0] data,
	input  wire logic        we_n,
	// stall length and captured beat
	input  wire logic [31:0] stall_len,
	output logic             external_wait_pin,
	output logic [22:0]      last_addr,
	output logic [15:0]      last_data
);
	logic we_q = 1'b1;
	int   left = 0;

	// latch each beat while the strobe is low, stall from its falling edge
	always @(posedge sys_clk) begin
		we_q <= we_n;
		if (!we_n && cs_n != 4'hF) begin
			last_addr <= addr;
			last_data <= data;
		end
		if (!we_n && we_q)
			left <= stall_len;
		else if (left > 0)
			left <= left - 1;
	end

	// wait is a driven output, low whenever no stall is running
	assign external_wait_pin = (left > 0);
endmodule

/* tb/test_async_write_normal_mode.sv */
// self-checking bench for the asynchronous write sequencer
`timescale 1ns/1ns
module test_async_write_normal_mode;
	import awn_pkg::*;
	logic                    sys_clk = 1'b0;
	logic                    sys_rst, req_valid, req_ready, write_is_top, read_done;
	awn_req_t                req;
	awn_cfg_t [CS_COUNT-1:0] cs_cfg;
	logic [CS_COUNT-1:0]     cs_n;
	logic [ADDR_W-1:0]       addr, m_addr;
	logic [BANK_W-1:0]       bank;
	logic [DATA_W-1:0]       dout, m_data;
	logic [BE_W-1:0]         be_n;
	logic                    oe, we_n, rd_n, wt, busy, write_done, last_wr;
	int                      stall_len, fail_count, num_checks;

	always #20 sys_clk = ~sys_clk;

	awn_write_seq #(.DEPTH(FIFO_DEPTH)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_ready(req_ready), .req(req),
		.write_is_top(write_is_top), .read_done(read_done), .cs_cfg(cs_cfg),
		.chip_select_pins_n(cs_n), .address_pins(addr), .bank_address_pins(bank),
		.data_pins_out(dout), .data_pins_oe(oe), .write_strobe_pin_n(we_n),
		.read_strobe_pin_n(rd_n), .byte_enable_pins_n(be_n), .external_wait_pin(wt),
		.busy(busy), .write_done(write_done));

	awn_mem_model mem (.sys_clk(sys_clk), .cs_n(cs_n), .addr(addr), .data(dout),
		.we_n(we_n), .stall_len(stall_len), .external_wait_pin(wt),
		.last_addr(m_addr), .last_data(m_data));

	task check(input logic ok, input string msg);
		num_checks++;
		if (!ok) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// pin levels that must hold on every cycle
	always @(negedge sys_clk) begin
		if (!sys_rst) begin
			check(rd_n === 1'b1, "read strobe low");
			if (we_n === 1'b1)
				check(be_n === BE_IDLE, "byte enables outside strobe");
		end
	end

	task pulse_read;
		@(posedge sys_clk);
		read_done <= 1'b1;
		@(posedge sys_clk);
		read_done <= 1'b0;
		last_wr = 1'b0;
	endtask

	// offer n requests back to back, holding valid until each is taken
	task push(input int c, input int n, input logic x, input logic [22:0] a,
			input logic [31:0] d);
		int g;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		for (int i = 0; i < n; i++) begin
			req <= '{cs: c[1:0], addr: a + 23'(i), bank: 2'h2, data: d + 32'(i),
				be_n: 4'h6, extra: x};
			g = 0;
			@(negedge sys_clk);
			while (req_ready !== 1'b1 && g < 50) begin
				g++;
				@(negedge sys_clk);
			end
			check(g < 50, "request never taken by the queue");
			@(posedge sys_clk);
		end
		req_valid <= 1'b0;
	endtask

	// follow one request on the pins and judge every phase
	task run_write(input int c, input logic [22:0] a, input logic [31:0] d, input int beats);
		int n, g, t, w;
		t = last_wr ? 0 : (cs_cfg[c].ta == TA_ZERO ? 1 : int'(cs_cfg[c].ta));
		n = 0;
		g = 0;
		@(negedge sys_clk);
		while (cs_n === CS_IDLE && g < 60) begin
			if (busy === 1'b1)
				n++;
			g++;
			@(negedge sys_clk);
		end
		check(n == t, "turnaround length");
		for (int b = 0; b < beats; b++) begin
			check(cs_n === ~(4'h1 << c) && addr === a + 23'(b) && bank === 2'h2, "setup pins");
			check(dout === d[16*b +: 16] && oe === 1'b1, "setup data");
			n = 0;
			while (we_n === 1'b1 && n < 60) begin
				n++;
				@(negedge sys_clk);
			end
			check(n == cs_cfg[c].setup + 1, "setup length");
			check(be_n === (b ? 2'h1 : 2'h2), "strobe byte enables");
			n = 0;
			while (we_n === 1'b0 && n < 120) begin
				n++;
				@(negedge sys_clk);
			end
			// synchronised wait is seen four edges after the pin, so it only
			// stretches a strobe whose natural end falls inside that window
			w = cs_cfg[c].strobe + 1;
			if (stall_len > 0 && w >= 6 && w <= stall_len + 5)
				w = stall_len + 6;
			check(n == w, "strobe length");
			n = 0;
			while (we_n === 1'b1 && cs_n !== CS_IDLE && addr === a + 23'(b) && n < 60) begin
				n++;
				@(negedge sys_clk);
			end
			check(n == cs_cfg[c].hold + 1, "hold length");
		end
		check(cs_n === CS_IDLE && write_done === 1'b1 && oe === 1'b0, "request end");
		check(m_addr === a + 23'(beats - 1) && m_data === d[16*(beats-1) +: 16], "stored");
		last_wr = 1'b1;
	endtask

	task start_top(input logic v);
		@(posedge sys_clk);
		write_is_top <= v;
	endtask

	task t_single;
		pulse_read();
		push(1, 1, 1'b0, 23'h000100, 32'hCAFE1234);
		start_top(1'b1);
		run_write(1, 23'h000100, 32'hCAFE1234, 1);
		start_top(1'b0);
	endtask

	task t_back;
		push(2, 2, 1'b0, 23'h000200, 32'h11110000);
		start_top(1'b1);
		run_write(2, 23'h000200, 32'h11110000, 1);
		run_write(2, 23'h000201, 32'h11110001, 1);
		start_top(1'b0);
	endtask

	task t_beats;
		pulse_read();
		push(3, 1, 1'b1, 23'h000300, 32'hBEEF5A5A);
		start_top(1'b1);
		run_write(3, 23'h000300, 32'hBEEF5A5A, 2);
		start_top(1'b0);
	endtask

	task t_wait;
		@(posedge sys_clk);
		stall_len <= 4;
		pulse_read();
		push(0, 1, 1'b0, 23'h000050, 32'h0000A55A);
		start_top(1'b1);
		run_write(0, 23'h000050, 32'h0000A55A, 1);
		start_top(1'b0);
		stall_len <= 0;
	endtask

	task t_abandon;
		int n;
		pulse_read();
		push(3, 1, 1'b0, 23'h0003F0, 32'h0F0FF0F0);
		repeat (5) @(negedge sys_clk);
		check(cs_n === CS_IDLE && busy === 1'b0, "started without priority");
		start_top(1'b1);
		start_top(1'b0);
		n = 0;
		repeat (10) begin
			@(negedge sys_clk);
			if (cs_n !== CS_IDLE)
				n++;
		end
		check(n == 0 && busy === 1'b0, "abandon after turnaround");
		start_top(1'b1);
		run_write(3, 23'h0003F0, 32'h0F0FF0F0, 1);
		start_top(1'b0);
	endtask

	task t_fill;
		push(0, FIFO_DEPTH, 1'b0, 23'h000400, 32'h50000000);
		@(negedge sys_clk);
		check(req_ready === 1'b0, "full queue took more");
		@(posedge sys_clk);
		stall_len <= 2;
		write_is_top <= 1'b1;
		for (int i = 0; i < FIFO_DEPTH; i++)
			run_write(0, 23'h000400 + 23'(i), 32'h50000000 + 32'(i), 1);
		start_top(1'b0);
		stall_len <= 0;
	endtask

	// watchdog against a hung sequence
	initial begin
		#(40 * 10000);
		fail_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		complete_run();
	end

	// reset, then the scenarios in turn
	initial begin
		sys_rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		write_is_top = 1'b0;
		read_done = 1'b0;
		stall_len = 0;
		last_wr = 1'b0;
		fail_count = 0;
		num_checks = 0;
		cs_cfg[0] = '{ta: 2'h2, setup: 4'h0, strobe: 6'h06, hold: 3'h1};
		cs_cfg[1] = '{ta: 2'h0, setup: 4'h2, strobe: 6'h03, hold: 3'h1};
		cs_cfg[2] = '{ta: 2'h3, setup: 4'h1, strobe: 6'h00, hold: 3'h2};
		cs_cfg[3] = '{ta: 2'h3, setup: 4'h0, strobe: 6'h01, hold: 3'h0};
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_single();
		t_back();
		t_beats();
		t_wait();
		t_abandon();
		t_fill();
		complete_run();
	end
endmodule
